// >>> shared/tcp_pkg.sv
package tcp_pkg;
  localparam logic [11:0] PTR_LO_OFF  = 12'h000;
  localparam logic [11:0] PTR_HI_OFF  = 12'h004;
  localparam logic [11:0] MASK_OFF    = 12'h008;
  localparam int BASE_W   = 41;
  localparam int FPP_W    = 19;
  localparam int MASK_W   = 12;
  localparam int FPP_LSB  = 4;
  localparam int BASE_LSB = 23;
  localparam int MASK_LSB = 13;
  localparam int VA_LSB   = 13;
  localparam logic [BASE_W-1:0] BASE_RST = 41'h0;
  localparam logic [FPP_W-1:0]  FPP_RST  = 19'h0;
  localparam logic [MASK_W-1:0] MASK_RST = 12'h000;

  typedef struct packed {
    logic        valid;
    logic [31:0] vaddr;
  } tcp_fault_t;

  typedef struct packed {
    logic              valid;
    logic [MASK_W-1:0] mask;
  } tcp_mask_xfer_t;

  typedef struct packed {
    logic              valid;
    logic [31:0]       vaddr;
    logic [FPP_W-1:0]  entry_vpn2;
    logic [MASK_W-1:0] entry_mask;
  } tcp_match_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
  } tcp_match_rsp_t;

  typedef struct packed {
    logic [BASE_W-1:0] base;
    logic [FPP_W-1:0]  fpp;
    logic [MASK_W-1:0] mask;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    tcp_mask_xfer_t    wr_out;
    tcp_match_rsp_t    match;
  } tcp_state_t;
endpackage : tcp_pkg

// >>> core/tcp_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - on a translation fault, capture virtual address bits 31:13 into the pair field
// - address bit 12 is never captured; one entry maps an even/odd pair
// - software base in the upper field is kept across fault captures
// - with 4K pages the pointer directly addresses a pair of 8-byte entries
// - reserved pointer bits read zero; software writes zeros there
// - the page-size mask register is software readable and writable
// - TLB read loads the mask register; TLB write copies it to the entry
// - stored mask bits select which address bits 24:13 join the tag compare
// - mask field sits in bits 24:13; bits 31:25 and 12:0 read zero
// - pointer is 64 bits: 41-bit base, 19-bit pair field, 4 zero bits
// - the pair field is written only by hardware on a translation fault
module tcp_regs (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire tcp_pkg::tcp_fault_t     fault,
  input  wire tcp_pkg::tcp_mask_xfer_t tlb_rd,
  input  wire logic                  tlb_wr_req,
  output tcp_pkg::tcp_mask_xfer_t    tlb_wr,
  input  wire tcp_pkg::tcp_match_req_t match_req,
  output tcp_pkg::tcp_match_rsp_t    match_rsp,
  output logic      [63:0]           ptr_out
);
  import tcp_pkg::*;

  tcp_state_t r;
  tcp_state_t next_r;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // bits 31:25 always compared; 24:13 dropped where mask is one
  function automatic logic vpn_hit(input logic [31:0]       va,
                                   input logic [FPP_W-1:0]  vpn2,
                                   input logic [MASK_W-1:0] msk);
    logic [FPP_W-1:0] care;
    care = {7'h7f, ~msk};
    return ((va[31:VA_LSB] ^ vpn2) & care) == 19'h0;
  endfunction : vpn_hit

  // reserved bits come out as zero by construction
  function automatic logic [31:0] ptr_lo_word(input logic [BASE_W-1:0] b,
                                              input logic [FPP_W-1:0]  f);
    return {b[8:0], f, 4'h0};
  endfunction : ptr_lo_word

  function automatic logic [31:0] mask_word(input logic [MASK_W-1:0] m);
    return {7'h00, m, 13'h0000};
  endfunction : mask_word

  logic        wr_hit;
  logic        setup;
  logic        mapped;
  logic [31:0] lo_new;
  logic [31:0] hi_new;
  logic [31:0] mk_new;

  always_comb begin
    next_r = r;
    setup  = psel && !penable;
    wr_hit = psel && penable && r.pready && pwrite && !r.pslverr;
    mapped = (paddr == PTR_LO_OFF) || (paddr == PTR_HI_OFF) || (paddr == MASK_OFF);
    lo_new = merge_strb(ptr_lo_word(r.base, r.fpp), pwdata, pstrb);
    hi_new = merge_strb(r.base[40:9], pwdata, pstrb);
    mk_new = merge_strb(mask_word(r.mask), pwdata, pstrb);

    // zero-wait-state slave: answer registered in setup, shown in access
    next_r.pready  = setup;
    next_r.pslverr = setup && !mapped;
    if (setup && !pwrite) begin
      unique case (paddr)
        PTR_LO_OFF: next_r.prdata = ptr_lo_word(r.base, r.fpp);
        PTR_HI_OFF: next_r.prdata = r.base[40:9];
        MASK_OFF:   next_r.prdata = mask_word(r.mask);
        default:    next_r.prdata = 32'h0000_0000;
      endcase
    end

    // software touches only the base; the pair field ignores writes
    if (wr_hit && paddr == PTR_LO_OFF) begin
      next_r.base[8:0] = lo_new[31:BASE_LSB];
    end
    if (wr_hit && paddr == PTR_HI_OFF) begin
      next_r.base[40:9] = hi_new;
    end
    // reserved write bits are dropped, so they can never read back
    if (wr_hit && paddr == MASK_OFF) begin
      next_r.mask = mk_new[24:MASK_LSB];
    end

    if (fault.valid) begin
      next_r.fpp = fault.vaddr[31:VA_LSB];
    end

    // a TLB read beats a same-cycle software write of the mask
    if (tlb_rd.valid) begin
      next_r.mask = tlb_rd.mask;
    end

    next_r.wr_out.valid = tlb_wr_req;
    if (tlb_wr_req) begin
      next_r.wr_out.mask = r.mask;
    end

    next_r.match.valid = match_req.valid;
    if (match_req.valid) begin
      next_r.match.hit = vpn_hit(match_req.vaddr, match_req.entry_vpn2,
                                 match_req.entry_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{base: BASE_RST, fpp: FPP_RST, mask: MASK_RST,
             prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
             wr_out: '{valid: 1'b0, mask: MASK_RST},
             match: '{valid: 1'b0, hit: 1'b0}};
    end else begin
      r <= next_r;
    end
  end

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign tlb_wr    = r.wr_out;
  assign match_rsp = r.match;
  assign ptr_out   = {r.base, r.fpp, 4'h0};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fault_cap;
    fault.valid |=> (r.fpp == $past(fault.vaddr[31:13]));
  endproperty
  a_fault_cap: assert property (p_fault_cap) else $error("pair field not captured");

  property p_no_bit12;
    fault.valid |=> (ptr_out[4] == $past(fault.vaddr[13]))
                    && (ptr_out[22] == $past(fault.vaddr[31]));
  endproperty
  a_no_bit12: assert property (p_no_bit12) else $error("pair field misaligned");

  property p_base_keep;
    (fault.valid && !wr_hit) |=> $stable(r.base);
  endproperty
  a_base_keep: assert property (p_base_keep) else $error("base lost on fault");

  property p_fpp_hw_only;
    !fault.valid |=> $stable(r.fpp);
  endproperty
  a_fpp_hw_only: assert property (p_fpp_hw_only) else $error("pair field changed");

  property p_ptr_zero;
    ptr_out[3:0] == 4'h0;
  endproperty
  a_ptr_zero: assert property (p_ptr_zero) else $error("pointer low bits set");

  property p_mask_rsv;
    (psel && penable && pready && !pwrite && paddr == MASK_OFF)
      |-> (prdata[31:25] == 7'h00) && (prdata[12:0] == 13'h0000);
  endproperty
  a_mask_rsv: assert property (p_mask_rsv) else $error("mask reserved bits set");

  property p_mask_wr;
    (wr_hit && paddr == MASK_OFF && pstrb == 4'hf && !tlb_rd.valid)
      |=> (r.mask == $past(pwdata[24:13]));
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_tlb_rd;
    tlb_rd.valid |=> (r.mask == $past(tlb_rd.mask));
  endproperty
  a_tlb_rd: assert property (p_tlb_rd) else $error("TLB read not loaded");

  property p_tlb_wr;
    tlb_wr_req |=> tlb_wr.valid && (tlb_wr.mask == $past(r.mask));
  endproperty
  a_tlb_wr: assert property (p_tlb_wr) else $error("TLB write mask wrong");

  property p_wide_hit;
    (match_req.valid && match_req.entry_mask == 12'hfff
     && match_req.vaddr[31:25] == match_req.entry_vpn2[18:12])
      |=> match_rsp.valid && match_rsp.hit;
  endproperty
  a_wide_hit: assert property (p_wide_hit) else $error("masked bits compared");

  property p_exact_miss;
    (match_req.valid && match_req.entry_mask == 12'h000
     && match_req.vaddr[31:13] != match_req.entry_vpn2)
      |=> match_rsp.valid && !match_rsp.hit;
  endproperty
  a_exact_miss: assert property (p_exact_miss) else $error("unmasked bit ignored");

  property p_apb_wait;
    (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB answer timing");

  property p_rd_lo;
    (psel && penable && pready && !pwrite && paddr == PTR_LO_OFF)
      |-> (prdata == $past(ptr_out[31:0]));
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("pointer low read wrong");

  property p_rd_hi;
    (psel && penable && pready && !pwrite && paddr == PTR_HI_OFF)
      |-> (prdata == $past(ptr_out[63:32]));
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("pointer high read wrong");

  property p_rd_mask;
    (psel && penable && pready && !pwrite && paddr == MASK_OFF)
      |-> (prdata[24:13] == $past(r.mask));
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");

  property p_hi_wr;
    (wr_hit && paddr == PTR_HI_OFF && pstrb == 4'hf)
      |=> (ptr_out[63:32] == $past(pwdata));
  endproperty
  a_hi_wr: assert property (p_hi_wr) else $error("base high write lost");

  property p_lo_wr;
    (wr_hit && paddr == PTR_LO_OFF && pstrb == 4'hf)
      |=> (ptr_out[31:23] == $past(pwdata[31:23]));
  endproperty
  a_lo_wr: assert property (p_lo_wr) else $error("base low write lost");

  property p_lo_fpp;
    (wr_hit && paddr == PTR_LO_OFF && !fault.valid)
      |=> $stable(ptr_out[22:4]);
  endproperty
  a_lo_fpp: assert property (p_lo_fpp) else $error("software reached pair field");

  property p_ptr_idle;
    (!wr_hit && !fault.valid) |=> $stable(ptr_out);
  endproperty
  a_ptr_idle: assert property (p_ptr_idle) else $error("pointer changed by itself");

  property p_mask_idle;
    (!wr_hit && !tlb_rd.valid) |=> $stable(r.mask);
  endproperty
  a_mask_idle: assert property (p_mask_idle) else $error("mask changed by itself");

  property p_tlb_wr_idle;
    !tlb_wr_req |=> !tlb_wr.valid;
  endproperty
  a_tlb_wr_idle: assert property (p_tlb_wr_idle) else $error("spurious TLB write");

  property p_match_idle;
    !match_req.valid |=> !match_rsp.valid;
  endproperty
  a_match_idle: assert property (p_match_idle) else $error("spurious compare answer");

  property p_top_cmp;
    (match_req.valid && match_req.vaddr[31:25] != match_req.entry_vpn2[18:12])
      |=> match_rsp.valid && !match_rsp.hit;
  endproperty
  a_top_cmp: assert property (p_top_cmp) else $error("upper bits not compared");

  property p_exact_hit;
    (match_req.valid && match_req.vaddr[31:13] == match_req.entry_vpn2)
      |=> match_rsp.valid && match_rsp.hit;
  endproperty
  a_exact_hit: assert property (p_exact_hit) else $error("equal tag missed");

  property p_unmapped;
    (psel && penable && pready && !pwrite && paddr != PTR_LO_OFF
     && paddr != PTR_HI_OFF && paddr != MASK_OFF)
      |-> pslverr && (prdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answer wrong");

  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");

  property p_mapped_ok;
    (psel && penable && pready && paddr == MASK_OFF)
      |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mask access refused");
endmodule : tcp_regs

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import tcp_pkg::*;
  logic           pclk = 1'b0;
  logic           presetn = 1'b0;
  logic [11:0]    paddr = 12'h000;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic [31:0]    pwdata = 32'h0;
  logic [3:0]     pstrb = 4'hf;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  tcp_fault_t     fault = '0;
  tcp_mask_xfer_t tlb_rd = '0;
  logic           tlb_wr_req = 1'b0;
  tcp_mask_xfer_t tlb_wr;
  tcp_match_req_t match_req = '0;
  tcp_match_rsp_t match_rsp;
  logic [63:0]    ptr_out;
  int             fail_count = 0;
  int             num_checks = 0;
  int             cycles = 0;
  logic [31:0]    rd;
  logic           er;

  tcp_regs u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault(fault), .tlb_rd(tlb_rd),
    .tlb_wr_req(tlb_wr_req), .tlb_wr(tlb_wr), .match_req(match_req),
    .match_rsp(match_rsp), .ptr_out(ptr_out));

  always #2.5 pclk = ~pclk;

  // ceiling well above the roughly 120 cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // request held until the edge at which pready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_reset();
    apb(PTR_LO_OFF, 1'b0, 32'h0); check(rd, 32'h0, "ptr lo reset");
    apb(PTR_HI_OFF, 1'b0, 32'h0); check(rd, 32'h0, "ptr hi reset");
    apb(MASK_OFF, 1'b0, 32'h0); check(rd, 32'h0, "mask reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_base();
    apb(PTR_HI_OFF, 1'b1, 32'hffffffff);
    apb(PTR_LO_OFF, 1'b1, 32'hfffffff0);
    apb(PTR_LO_OFF, 1'b0, 32'h0); check(rd, 32'hff800000, "pair and zero bits");
    apb(PTR_HI_OFF, 1'b0, 32'h0); check(rd, 32'hffffffff, "base high");
    #1 check(ptr_out, 64'hffffffff_ff800000, "pointer layout");
    $display("test base done");
  endtask : t_base

  task automatic t_fault(input logic [31:0] va);
    @(posedge pclk); fault <= '{1'b1, va};
    @(posedge pclk); fault <= '0;
    #1 check(ptr_out, {32'hffffffff, 9'h1ff, va[31:13], 4'h0}, "fault capture");
    apb(PTR_LO_OFF, 1'b0, 32'h0); check(rd, {9'h1ff, va[31:13], 4'h0}, "entry addr");
    $display("test fault done");
  endtask : t_fault

  task automatic t_mask();
    apb(MASK_OFF, 1'b1, 32'h01ffe000);
    apb(MASK_OFF, 1'b0, 32'h0); check(rd, 32'h01ffe000, "mask field");
    @(posedge pclk); tlb_wr_req <= 1'b1;
    @(posedge pclk); tlb_wr_req <= 1'b0;
    #1 check(tlb_wr, {1'b1, 12'hfff}, "tlb write mask");
    @(posedge pclk); tlb_rd <= '{1'b1, 12'h003};
    @(posedge pclk); tlb_rd <= '0;
    apb(MASK_OFF, 1'b0, 32'h0); check(rd, 32'h00006000, "tlb read mask");
    $display("test mask done");
  endtask : t_mask

  // each mask bit lets exactly its own address bit differ
  task automatic t_match();
    logic [18:0] vpn;
    vpn = 19'h2a5c3;
    for (int i = 0; i < 12; i++) begin
      for (int m = 0; m < 2; m++) begin
        @(posedge pclk);
        match_req <= '{1'b1, {vpn ^ (19'h1 << i), 13'h0}, vpn, m ? (12'h1 << i) : 12'h0};
        @(posedge pclk); match_req <= '0;
        #1 check(match_rsp, {1'b1, m[0]}, "tag compare");
      end
    end
    @(posedge pclk);
    match_req <= '{1'b1, {vpn ^ 19'h40000, 13'h0}, vpn, 12'hfff};
    @(posedge pclk);
    match_req <= '0;
    #1 check(match_rsp, {1'b1, 1'b0}, "top bits compared");
    $display("test match done");
  endtask : t_match

  task automatic t_unmapped();
    apb(12'h00c, 1'b1, 32'hffffffff); check(er, 1'b1, "unmapped write err");
    apb(12'h00c, 1'b0, 32'h0); check({er, rd}, {1'b1, 32'h0}, "unmapped read");
    apb(MASK_OFF, 1'b0, 32'h0); check(rd, 32'h00006000, "mask kept");
    $display("test unmapped done");
  endtask : t_unmapped

  // a one-byte strobe may only touch its own lane
  task automatic t_strobe();
    pstrb <= 4'h1;
    apb(PTR_HI_OFF, 1'b1, 32'h000000a5);
    pstrb <= 4'hf;
    apb(PTR_HI_OFF, 1'b0, 32'h0);
    check(rd, 32'hffffffa5, "byte strobe");
    $display("test strobe done");
  endtask : t_strobe

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_base();
    t_fault(32'h12345fff);
    t_fault(32'h12344fff);
    t_mask();
    t_match();
    t_unmapped();
    t_strobe();
    give_verdict();
  end
endmodule : testbench
